/* File: inc/asram_pkg.sv */
/*
 package of the asynchronous 1M x 4 static memory host controller:
 widths, pin and request structs, state codes and timing counts.
 assumes a 50 MHz mclk (20 ns period).
*/
package asram_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 4;

	// ----------------------------------------------------------------
	// timing, figures in their own units
	// ----------------------------------------------------------------
	localparam int CLK_PS                  = 20000;
	localparam int READ_CYCLE_MIN_PS       = 10000;
	localparam int ADDR_TO_VALID_MAX_PS    = 10000;
	localparam int SELECT_TO_VALID_MAX_PS  = 10000;
	localparam int DRIVE_TO_VALID_MAX_PS   = 5000;
	localparam int DRIVE_OFF_FLOAT_MAX_PS  = 5000;
	localparam int WRITE_CYCLE_MIN_PS      = 10000;
	localparam int STROBE_PULSE_MIN_PS     = 7000;
	localparam int ADDR_SETUP_TO_END_MIN_PS = 7000;
	localparam int DATA_SETUP_TO_END_MIN_PS = 6000;
	localparam int STROBE_LOW_FLOAT_MAX_PS = 5000;
	localparam int FIRST_ACCESS_WAIT_US    = 100;

	// ----------------------------------------------------------------
	// cycle counts, least times rounded up, never below one
	// ----------------------------------------------------------------
	function automatic int cyc_up(input int ps);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// read sample waits for the address-to-valid time only
	localparam int READ_WAIT_CYC = cyc_up(ADDR_TO_VALID_MAX_PS);
	localparam int READ_CYC_MIN  = cyc_up(READ_CYCLE_MIN_PS);
	// strobe low long enough for pulse plus strobe-low float time
	localparam int WR_LOW_CYC    = cyc_up(STROBE_PULSE_MIN_PS
		+ STROBE_LOW_FLOAT_MAX_PS);
	localparam int WR_CYC_MIN    = cyc_up(WRITE_CYCLE_MIN_PS);
	localparam int FLOAT_CYC     = cyc_up(DRIVE_OFF_FLOAT_MAX_PS);
	localparam int POWER_WAIT_CYC = FIRST_ACCESS_WAIT_US * 1000000 / CLK_PS;
	localparam int CNT_W = 13;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asram_req_t;

	typedef struct packed {
		logic              sel_n;
		logic              drive_n;
		logic              strobe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] doe_n;
	} asram_pins_t;

	typedef enum logic [2:0] {
		ST_POWER = 3'h0,
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h3,
		ST_RDONE = 3'h2,
		ST_WRITE = 3'h6,
		ST_WEND  = 3'h7,
		ST_GAP   = 3'h5
	} asram_state_t;

endpackage

/* File: src/asram_timer.sv */
/*
 down counter used by the host controller for power-up and strobe timing.
 assumes one clock domain and an active-high asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module asram_timer
	import asram_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] value,
	output logic                  done
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (load)
			nxt_cnt = value;
		else if (cnt_ff != '0)
			nxt_cnt = cnt_ff - 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign done = (cnt_ff == '0) && !load;

endmodule // asram_timer
`default_nettype wire

/* File: src/asram_host.sv */
/*
 host controller for an asynchronous 1M x 4 static memory: takes single
 read or write requests and drives the memory's three active-low strobes,
 address and shared data bus with the documented minimum timing.
 assumes mclk at 50 MHz, memory pins wired directly, data in synchronous.
*/
// Operation
// - a write begins only with select and write strobe both low.
// - write data stands 6 ns before and through the ending edge.
// - with drive low a strobe-ended write spans 5 ns plus 6 ns.
// - the host never drives the data bus while the memory drives it.
// - a read keeps the write strobe high for its whole cycle.
// - the first access waits at least 100 us after power is stable.
// - read data is valid 10 ns after address; reads span 10 ns.
// - writes span 10 ns, strobe 7 ns, address set 7 ns before end.
`timescale 1ns/10ps
`default_nettype none
module asram_host
	import asram_pkg::*;
#(
	parameter int POWER_WAIT = POWER_WAIT_CYC
)
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire asram_pkg::asram_req_t req,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	output logic [asram_pkg::DATA_W-1:0] rdata,
	output logic                      rdata_valid,
	output logic                      wr_done,
	output asram_pkg::asram_pins_t    pins,
	input  wire logic [asram_pkg::DATA_W-1:0] mem_din
);
	import asram_pkg::*;

	// ----------------------------------------------------------------
	// state and registered pins
	// ----------------------------------------------------------------
	asram_state_t      state_ff, nxt_state;
	asram_pins_t       pins_ff, nxt_pins;
	logic              ready_ff, nxt_ready;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic              rvalid_ff, nxt_rvalid;
	logic              wdone_ff, nxt_wdone;
	logic              tmr_load;
	logic [CNT_W-1:0]  tmr_value;
	logic              tmr_done;
	logic              start_ff, nxt_start;
	logic [CNT_W-1:0]  power_value;

	asram_timer u_timer (
		.mclk  (mclk),
		.rst   (rst),
		.load  (tmr_load),
		.value (tmr_value),
		.done  (tmr_done)
	);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_pins   = pins_ff;
		nxt_ready  = 1'b0;
		nxt_rdata  = rdata_ff;
		nxt_rvalid = 1'b0;
		nxt_wdone  = 1'b0;
		tmr_load   = 1'b0;
		tmr_value  = '0;
		unique case (state_ff)
			ST_POWER:
			begin
				// load the wait once, then hold until it runs out
				if (!start_ff)
				begin
					tmr_load  = 1'b1;
					tmr_value = power_value;
				end
				else if (tmr_done)
				begin
					nxt_state = ST_IDLE;
					nxt_ready = 1'b1;
				end
			end
			ST_IDLE:
			begin
				nxt_ready = 1'b1;
				if (req_valid && ready_ff)
				begin
					nxt_ready      = 1'b0;
					nxt_pins.addr  = req.addr;
					nxt_pins.sel_n = 1'b0;
					tmr_load       = 1'b1;
					if (req.wr)
					begin
						// drive stays high so the memory floats
						nxt_pins.drive_n  = 1'b1;
						nxt_pins.strobe_n = 1'b0;
						nxt_pins.dout     = req.wdata;
						nxt_pins.doe_n    = '0;
						tmr_value = CNT_W'(WR_LOW_CYC - 1);
						nxt_state = ST_WRITE;
					end
					else
					begin
						nxt_pins.strobe_n = 1'b1;
						nxt_pins.drive_n  = 1'b0;
						nxt_pins.doe_n    = '1;
						tmr_value = CNT_W'(READ_WAIT_CYC - 1);
						nxt_state = ST_READ;
					end
				end
			end
			ST_READ:
			begin
				if (tmr_done)
				begin
					nxt_rdata  = mem_din;
					nxt_rvalid = 1'b1;
					nxt_pins.drive_n = 1'b1;
					nxt_pins.sel_n   = 1'b1;
					nxt_state  = ST_RDONE;
				end
			end
			ST_RDONE:
			begin
				// memory floats before the host may drive again
				tmr_load  = 1'b1;
				tmr_value = CNT_W'(FLOAT_CYC - 1);
				nxt_state = ST_GAP;
			end
			ST_WRITE:
			begin
				if (tmr_done)
				begin
					// both rise together, data still driven
					nxt_pins.strobe_n = 1'b1;
					nxt_pins.sel_n    = 1'b1;
					nxt_state = ST_WEND;
				end
			end
			ST_WEND:
			begin
				nxt_pins.doe_n = '1;
				nxt_wdone = 1'b1;
				tmr_load  = 1'b1;
				tmr_value = CNT_W'(WR_CYC_MIN - 1);
				nxt_state = ST_GAP;
			end
			ST_GAP:
			begin
				if (tmr_done)
				begin
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_ff  <= ST_POWER;
			pins_ff   <= '{sel_n: 1'b1, drive_n: 1'b1, strobe_n: 1'b1,
				addr: '0, dout: '0, doe_n: '1};
			ready_ff  <= 1'b0;
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
			wdone_ff  <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			pins_ff   <= nxt_pins;
			ready_ff  <= nxt_ready;
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			wdone_ff  <= nxt_wdone;
		end
	end

	// ----------------------------------------------------------------
	// power-up wait start
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_start = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			start_ff <= 1'b0;
		else
			start_ff <= nxt_start;
	end

	assign power_value = CNT_W'(POWER_WAIT);

	assign req_ready   = ready_ff;
	assign rdata       = rdata_ff;
	assign rdata_valid = rvalid_ff;
	assign wr_done     = wdone_ff;
	assign pins        = pins_ff;

endmodule // asram_host
`default_nettype wire

/* File: verification/asram_host_properties.sv */
/*
 checker of host pin order and answers.
 assumes bind onto asram_host.
*/
`timescale 1ns/10ps
`default_nettype none
module asram_host_properties
	import asram_pkg::*;
(
	input wire logic                  mclk,
	input wire logic                  rst,
	input wire asram_pkg::asram_req_t req,
	input wire logic                  req_valid,
	input wire logic                  req_ready,
	input wire logic [3:0]            rdata,
	input wire logic                  rdata_valid,
	input wire logic                  wr_done,
	input wire asram_pkg::asram_pins_t pins,
	input wire logic [3:0]            mem_din
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic take;
	assign take = req_valid && req_ready;
	// ----
	// pins
	// ----
	property p_rd_wr_high; !pins.sel_n && !pins.drive_n |-> pins.strobe_n;
	endproperty
	a_rd_wr_high: assert property (p_rd_wr_high)
		else $error("strobe low in read");
	property p_no_clash; !pins.drive_n |-> pins.doe_n == 4'hf; endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("bus clash");
	property p_wr_start; $fell(pins.strobe_n) |-> !pins.sel_n; endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("strobe without select");
	property p_wr_end; $rose(pins.strobe_n) |-> $rose(pins.sel_n); endproperty
	a_wr_end: assert property (p_wr_end)
		else $error("write end split");
	property p_wr_hold; $rose(pins.strobe_n) |-> pins.doe_n == 4'h0
		&& $stable(pins.dout) && $stable(pins.addr); endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write data not held");
	property p_wr_oe; !pins.strobe_n |-> pins.drive_n; endproperty
	a_wr_oe: assert property (p_wr_oe)
		else $error("drive low in write");
	property p_addr; !pins.sel_n |=> $stable(pins.addr);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address moved");
	// ----
	// answers
	// ----
	property p_rd_ans; take && !req.wr |-> ##2 rdata_valid
		&& rdata == $past(mem_din); endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read answer wrong");
	property p_wr_ans; take && req.wr |-> ##3 wr_done; endproperty
	a_wr_ans: assert property (p_wr_ans)
		else $error("write answer late");
	property p_wr_pins; take && req.wr |=> !pins.strobe_n && !pins.sel_n
		&& pins.addr == $past(req.addr)
		&& pins.dout == $past(req.wdata); endproperty
	a_wr_pins: assert property (p_wr_pins)
		else $error("write pins wrong");
endmodule // asram_host_properties
bind asram_host asram_host_properties u_props (.mclk(mclk), .rst(rst),
	.req(req), .req_valid(req_valid), .req_ready(req_ready),
	.rdata(rdata), .rdata_valid(rdata_valid), .wr_done(wr_done),
	.pins(pins), .mem_din(mem_din));
`default_nettype wire

/* File: verification/asram_mem_model.sv */
/*
 behavioural 1M x 4 static memory.
 assumes pins straight from the host.
*/
`timescale 1ns/10ps
`default_nettype none
module asram_mem_model
	import asram_pkg::*;
(
	input wire asram_pkg::asram_pins_t pins,
	output logic [3:0]                 mem_din
);
	logic [3:0]  mem [logic [19:0]];
	logic [19:0] wa;
	logic [3:0]  wd;
	logic [3:0]  last = 4'h0;
	logic        wact = 1'b0;
	// store at end of overlap
	always @(pins) begin
		if (!pins.sel_n && !pins.strobe_n) begin
			wa = pins.addr;
			wd = (pins.doe_n == 4'h0) ? pins.dout : 4'hx;
			wact = 1'b1;
		end else if (wact) begin
			mem[wa] = wd;
			wact = 1'b0;
		end
	end
	// read drive, else stale value flipped
	always @(pins) begin
		if (!pins.sel_n && !pins.drive_n && pins.strobe_n) begin
			mem_din = mem.exists(pins.addr) ? mem[pins.addr] : 4'h0;
			if (pins.doe_n != 4'hf) mem_din = 4'hx;
			last = mem_din;
		end else begin
			mem_din = ~last;
		end
	end
endmodule // asram_mem_model
`default_nettype wire

/* File: verification/asram_host_tb.sv */
/*
 testbench of the host with a memory model.
 assumes nothing outside.
*/
`timescale 1ns/10ps
`default_nettype none
module asram_host_tb;
	import asram_pkg::*;
	logic        mclk, rst, req_valid, req_ready, rdata_valid, wr_done;
	asram_req_t  req;
	asram_pins_t pins;
	logic [3:0]  rdata, mem_din, d;
	logic [19:0] a;
	logic [19:0] q[$];
	logic [3:0]  exp_mem [logic [19:0]];
	int          num_errors, checks;
	localparam int PWAIT = 4;
	asram_host #(.POWER_WAIT(PWAIT)) u_dut (.mclk(mclk), .rst(rst), .req(req),
		.req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
		.rdata_valid(rdata_valid), .wr_done(wr_done), .pins(pins),
		.mem_din(mem_din));
	asram_mem_model u_mem (.pins(pins), .mem_din(mem_din));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %0t %h %h", $time, got, exp);
		end
	endtask
	function automatic logic [3:0] expect_rd(input logic [19:0] ad);
		return exp_mem.exists(ad) ? exp_mem[ad] : 4'h0;
	endfunction
	task automatic access(input logic w, input logic [19:0] ad,
		input logic [3:0] dt);
		int n;
		@(posedge mclk);
		req <= '{w, ad, dt};
		req_valid <= 1'b1;
		n = 0;
		do @(negedge mclk); while (req_ready !== 1'b1 && ++n < 50);
		if (req_ready !== 1'b1)
		begin
			num_errors++;
			conclude();
		end
		@(posedge mclk);
		req_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
			if (n == 1) check(req_ready, 0);
		end while ((w ? wr_done : rdata_valid) !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			num_errors++;
			conclude();
		end
		if (w)
		begin
			exp_mem[ad] = dt;
			check(n, WR_LOW_CYC + 2);
		end
		else
		begin
			check(n, READ_WAIT_CYC + 1);
			check(rdata, expect_rd(ad));
		end
	endtask
	initial
	begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		num_errors = 0;
		checks = 0;
		void'($urandom(32'h0d8fe16d));
		repeat (16) @(posedge mclk);
		check({pins.sel_n, pins.strobe_n, pins.doe_n}, 6'h3f);
		rst <= 1'b0;
		repeat (PWAIT)
		begin
			@(negedge mclk);
			check(req_ready, 0);
		end
		access(1'b1, 20'h0, 4'h0);
		access(1'b1, 20'hfffff, 4'hf);
		access(1'b1, 20'h5, 4'ha);
		access(1'b1, 20'h5, 4'h5);
		access(1'b0, 20'h5, 4'h0);
		access(1'b0, 20'h0, 4'h0);
		access(1'b0, 20'hfffff, 4'h0);
		repeat (24)
		begin
			a = 20'($urandom);
			d = 4'($urandom);
			q.push_back(a);
			access(1'b1, a, d);
		end
		foreach (q[i]) access(1'b0, q[i], 4'h0);
		@(posedge mclk);
		req <= '{1'b1, 20'habc, 4'h9};
		req_valid <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b1;
		req_valid <= 1'b0;
		@(negedge mclk);
		check({pins.sel_n, pins.strobe_n, pins.doe_n}, 6'h3f);
		@(posedge mclk);
		rst <= 1'b0;
		repeat (PWAIT)
		begin
			@(negedge mclk);
			check(req_ready, 0);
		end
		access(1'b0, 20'hfffff, 4'h0);
		conclude();
	end
endmodule // asram_host_tb
`default_nettype wire
